//--- hdl/cvzs_map.vh
// Register map, field positions, reset values and timing of the sequencer
`ifndef CVZS_MAP_VH
`define CVZS_MAP_VH

`define CVZS_NZ 4
// Word offsets as byte addresses
`define CVZS_OFF_CTRL 5'h00
`define CVZS_OFF_TIMER 5'h04
`define CVZS_OFF_JOG 5'h08
`define CVZS_OFF_STAT 5'h0c
`define CVZS_OFF_IMAGE 5'h10
`define CVZS_OFF_NADDR 5'h14
// Control fields
`define CVZS_CTRL_POL 3:0
`define CVZS_CTRL_QEN 7:4
`define CVZS_CTRL_SING 11:8
`define CVZS_CTRL_HACC 15:12
`define CVZS_CTRL_AUXLAST 16
`define CVZS_CTRL_AUXPOL 17
`define CVZS_CTRL_RST 32'h0000000f
// Timer fields, tenths of a second
`define CVZS_TMR_ARR 7:0
`define CVZS_TMR_CLR 15:8
`define CVZS_TMR_JAM 23:16
`define CVZS_TMR_UNJ 31:24
`define CVZS_TMR_RST 32'h14640a64
// Jog fields
`define CVZS_JOG_EN 3:0
`define CVZS_JOG_REV 7:4
// Network image
`define CVZS_ZONE_BITS 8
`define CVZS_NADDR_MIN 8'h10
// Timer tick
`define CVZS_TICK_MS 100
`define CVZS_CLK_KHZ 20000

`endif

//--- hdl/cvzs_tmr.v
// Per-zone down counter in tenth-second ticks
`timescale 1ns/1ns
module cvzs_tmr (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire load_i,
  input wire [7:0] val_i,
  input wire tick_i,
  output wire done_o
);

  reg [7:0] cnt_r;

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 8'h00;
    end else if (load_i) begin
      cnt_r <= val_i;
    end else if (tick_i && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  assign done_o = (cnt_r == 8'h00);

endmodule // cvzs_tmr

//--- hdl/cvzs_top.v
// Four-zone conveyor sequencer with Avalon-MM register slave
//
// How it works
// - Motor power indicator lights only while motor supply is judged good.
// - Sensor blocked level programmable; optional quality input qualifies it.
// - No trays and no start request: motor stays stopped.
// - Upstream start request runs motor forward and starts arrival timer.
// - Arrival timer expiring before sensor blocks stops motor.
// - Blocked sensor raises start request to downstream zone.
// - Blocked sensor starts jam timer; still blocked at expiry means jam.
// - Sensor clearing runs motor for clear interval, then stops.
// - Zero clear interval runs until next tray or downstream sensor blocks.
// - Accumulate from downstream or host stops motor once tray blocks.
// - Zone held under accumulation asserts accumulate upstream.
// - Accumulate removed: held zone moves tray on, drops upstream accumulate.
// - Zone waiting in arrival interval asserts accumulate upstream.
// - Aux last-release mode: inactive pulse releases exactly one head tray.
// - Singulate zone holds upstream accumulate until its tray clears.
// - Jam detection only outside jog; jam sets host-readable status bit.
// - Jam with zero unjam interval stops motor.
// - Jam with nonzero unjam interval reverses motor.
// - Unjam expiry with sensor blocked stops motor, flashes fault light.
// - Clear sensor leaves jam state, including removal by hand.
// - Host jog bits run motor forward or reverse, bypassing sequencing.
// - Eight image bits per zone; network address at least sixteen.
// - Zero jam interval disables jam detection, motor keeps forward.
// - Sensor clearing during reversal returns to forward operation.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "cvzs_map.vh"
module cvzs_top #(
  parameter TICK_CYC = `CVZS_TICK_MS * `CVZS_CLK_KHZ
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [2:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire [3:0] sens_i,
  input wire [3:0] qual_i,
  input wire aux_i,
  input wire start_up_i,
  input wire acc_dn_i,
  input wire blk_dn_i,
  input wire mpwr_ok_i,
  output reg start_dn_o,
  output reg acc_up_o,
  output reg [3:0] mot_fwd_o,
  output reg [3:0] mot_rev_o,
  output reg mpwr_led_o,
  output reg fault_led_o
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ARR = 3'h1;
  localparam ST_BLK = 3'h2;
  localparam ST_HOLD = 3'h3;
  localparam ST_CLR = 3'h4;
  localparam ST_REV = 3'h5;
  localparam ST_STOP = 3'h6;

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer k;
    begin
      be_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          be_merge[k*8 +: 8] = wd[k*8 +: 8];
        end
      end
    end
  endfunction

  function is_jam;
    input [2:0] st;
    begin
      is_jam = (st == ST_REV) || (st == ST_STOP);
    end
  endfunction

  // ==========================================================
  // Register slave
  // ==========================================================
  reg [31:0] ctrl_r;
  reg [31:0] tmr_r;
  reg [7:0] jog_r;
  reg [7:0] naddr_r;
  wire [4:0] byte_addr = {avs_address_i, 2'b00};
  wire req = avs_read_i | avs_write_i;
  wire wr_go = avs_write_i & ~avs_waitrequest_o;
  wire [3:0] jam_w;
  wire [3:0] flt_w;
  wire [3:0] blk_w;
  wire [3:0] run_w;
  wire [3:0] rev_w;
  wire [3:0] start_w;
  wire [3:0] accup_w;
  wire [31:0] image_w;
  wire [31:0] naddr_wd;
  wire [31:0] jog_wd;
  reg [31:0] rd_nxt;

  assign naddr_wd = be_merge({24'h000000, naddr_r}, avs_writedata_i,
                             avs_byteenable_i);
  assign jog_wd = be_merge({24'h000000, jog_r}, avs_writedata_i,
                           avs_byteenable_i);

  always @* begin
    case (byte_addr)
      `CVZS_OFF_CTRL: rd_nxt = ctrl_r;
      `CVZS_OFF_TIMER: rd_nxt = tmr_r;
      `CVZS_OFF_JOG: rd_nxt = {24'h000000, jog_r};
      `CVZS_OFF_STAT: rd_nxt = {18'h00000, fault_led_o, mpwr_led_o,
                                run_w, blk_w, jam_w};
      `CVZS_OFF_IMAGE: rd_nxt = image_w;
      `CVZS_OFF_NADDR: rd_nxt = {24'h000000, naddr_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // One wait cycle per access, then acknowledge
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= rd_nxt;
      end
    end
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= `CVZS_CTRL_RST;
      tmr_r <= `CVZS_TMR_RST;
      jog_r <= 8'h00;
      naddr_r <= `CVZS_NADDR_MIN;
    end else if (wr_go) begin
      case (byte_addr)
        `CVZS_OFF_CTRL: ctrl_r <= be_merge(ctrl_r, avs_writedata_i,
                                           avs_byteenable_i);
        `CVZS_OFF_TIMER: tmr_r <= be_merge(tmr_r, avs_writedata_i,
                                           avs_byteenable_i);
        `CVZS_OFF_JOG: jog_r <= jog_wd[7:0];
        `CVZS_OFF_NADDR: begin
          if (naddr_wd[7:0] >= `CVZS_NADDR_MIN) begin
            naddr_r <= naddr_wd[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Tick, indicators, aux release
  // ==========================================================
  reg [21:0] pre_r;
  reg tick_r;
  reg flash_r;
  reg aux_act_r;
  reg rel_r;
  reg head_blk_d_r;
  wire aux_act = aux_i ~^ ctrl_r[`CVZS_CTRL_AUXPOL];
  wire aux_last = ctrl_r[`CVZS_CTRL_AUXLAST];
  wire acc_head = acc_dn_i | (aux_last & aux_act & ~rel_r);

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_r <= 22'h000000;
      tick_r <= 1'b0;
      flash_r <= 1'b0;
    end else begin
      tick_r <= (pre_r == TICK_CYC[21:0] - 22'h000001);
      if (pre_r == TICK_CYC[21:0] - 22'h000001) begin
        pre_r <= 22'h000000;
      end else begin
        pre_r <= pre_r + 22'h000001;
      end
      if (tick_r) begin
        flash_r <= ~flash_r;
      end
    end
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aux_act_r <= 1'b0;
      rel_r <= 1'b0;
      head_blk_d_r <= 1'b0;
    end else begin
      aux_act_r <= aux_act;
      head_blk_d_r <= blk_w[3];
      if (aux_last && aux_act_r && !aux_act) begin
        rel_r <= 1'b1;
      end else if (head_blk_d_r && !blk_w[3]) begin
        rel_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Zone sequencers
  // ==========================================================
  wire [3:0] start_src = {start_w[2:0], start_up_i};
  wire [3:0] acc_src = {acc_head, accup_w[3:1]} |
                       ctrl_r[`CVZS_CTRL_HACC];
  wire [3:0] blk_dn = {blk_dn_i, blk_w[3:1]};

  genvar g;
  generate
    for (g = 0; g < `CVZS_NZ; g = g + 1) begin : g_zone
      reg [2:0] st_r;
      reg [2:0] st_nxt;
      reg blk_r;
      reg flt_r;
      reg flt_nxt;
      reg ld;
      reg [7:0] ld_val;
      wire jog = jog_r[g];
      wire tdone;
      wire [7:0] t_arr = tmr_r[`CVZS_TMR_ARR];
      wire [7:0] t_clr = tmr_r[`CVZS_TMR_CLR];
      wire [7:0] t_jam = tmr_r[`CVZS_TMR_JAM];
      wire [7:0] t_unj = tmr_r[`CVZS_TMR_UNJ];

      cvzs_tmr u_tmr (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .load_i(ld),
        .val_i(ld_val),
        .tick_i(tick_r & ~jog),
        .done_o(tdone)
      );

      // Quality low holds the last trusted reading
      always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          blk_r <= 1'b0;
        end else if (!ctrl_r[4 + g] || qual_i[g]) begin
          blk_r <= sens_i[g] ~^ ctrl_r[g];
        end
      end

      always @* begin
        st_nxt = st_r;
        flt_nxt = flt_r;
        ld = 1'b0;
        ld_val = t_arr;
        case (st_r)
          ST_IDLE: begin
            if (blk_r) begin
              st_nxt = acc_src[g] ? ST_HOLD : ST_BLK;
              ld = 1'b1;
              ld_val = t_jam;
            end else if (start_src[g]) begin
              st_nxt = ST_ARR;
              ld = 1'b1;
              ld_val = t_arr;
            end
          end
          ST_ARR: begin
            if (blk_r) begin
              st_nxt = acc_src[g] ? ST_HOLD : ST_BLK;
              ld = 1'b1;
              ld_val = t_jam;
            end else if (tdone) begin
              st_nxt = ST_IDLE;
            end
          end
          ST_BLK: begin
            if (!blk_r) begin
              st_nxt = ST_CLR;
              ld = 1'b1;
              ld_val = t_clr;
            // Accumulate only stops a newly arriving tray
            end else if (t_jam != 8'h00 && tdone) begin
              st_nxt = (t_unj == 8'h00) ? ST_STOP : ST_REV;
              ld = 1'b1;
              ld_val = t_unj;
            end
          end
          ST_HOLD: begin
            if (!blk_r) begin
              st_nxt = ST_IDLE;
            end else if (!acc_src[g]) begin
              st_nxt = ST_BLK;
              ld = 1'b1;
              ld_val = t_jam;
            end
          end
          ST_CLR: begin
            if (blk_r) begin
              st_nxt = acc_src[g] ? ST_HOLD : ST_BLK;
              ld = 1'b1;
              ld_val = t_jam;
            end else if (t_clr == 8'h00) begin
              if (blk_dn[g]) begin
                st_nxt = ST_IDLE;
              end
            end else if (tdone) begin
              st_nxt = ST_IDLE;
            end
          end
          ST_REV: begin
            if (!blk_r) begin
              st_nxt = ST_ARR;
              ld = 1'b1;
              ld_val = t_arr;
            end else if (tdone) begin
              st_nxt = ST_STOP;
              flt_nxt = 1'b1;
            end
          end
          ST_STOP: begin
            if (!blk_r) begin
              st_nxt = ST_IDLE;
              flt_nxt = 1'b0;
            end
          end
          default: st_nxt = ST_IDLE;
        endcase
      end

      // Jog freezes the machine and its timer
      always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          st_r <= ST_IDLE;
          flt_r <= 1'b0;
        end else if (!jog) begin
          st_r <= st_nxt;
          flt_r <= flt_nxt;
        end
      end

      assign jam_w[g] = is_jam(st_r);
      assign flt_w[g] = flt_r;
      assign blk_w[g] = blk_r;
      assign rev_w[g] = jog ? jog_r[4 + g] : (st_r == ST_REV);
      assign run_w[g] = jog ? ~jog_r[4 + g] :
                        (st_r == ST_ARR) || (st_r == ST_BLK) ||
                        (st_r == ST_CLR);
      assign start_w[g] = (st_r == ST_BLK) || (st_r == ST_HOLD) ||
                          (st_r == ST_CLR);
      assign accup_w[g] = (st_r == ST_ARR) || (st_r == ST_HOLD) ||
                          (ctrl_r[8 + g] && st_r == ST_BLK);
      assign image_w[g*8 +: 8] = {jam_w[g], flt_r, blk_r, run_w[g],
                                  rev_w[g], accup_w[g], start_w[g],
                                  jog};
    end
  endgenerate

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mot_fwd_o <= 4'h0;
      mot_rev_o <= 4'h0;
      start_dn_o <= 1'b0;
      acc_up_o <= 1'b0;
      mpwr_led_o <= 1'b0;
      fault_led_o <= 1'b0;
    end else begin
      mot_fwd_o <= run_w;
      mot_rev_o <= rev_w;
      start_dn_o <= start_w[3];
      acc_up_o <= accup_w[0];
      mpwr_led_o <= mpwr_ok_i;
      fault_led_o <= (|flt_w) & flash_r;
    end
  end

endmodule // cvzs_top

//--- dv/cvzs_chk_asserts.sv
// Port-level assertion checker for the conveyor zone sequencer
`timescale 1ns/1ns
module cvzs_chk #(
  parameter TICK_CYC = 20
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire avs_waitrequest_o,
  input wire [3:0] sens_i,
  input wire start_up_i,
  input wire acc_dn_i,
  input wire mpwr_ok_i,
  input wire start_dn_o,
  input wire acc_up_o,
  input wire [3:0] mot_fwd_o,
  input wire [3:0] mot_rev_o,
  input wire mpwr_led_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========
  // Sequences
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_arrive;
    ##[1:4] (mot_fwd_o[0] && acc_up_o);
  endsequence
  // ==========
  // Properties
  property p_pwr;
    $past(rst_b_i) |-> mpwr_led_o == $past(mpwr_ok_i);
  endproperty
  property p_ack;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_ack;
  endproperty
  property p_excl;
    (mot_fwd_o & mot_rev_o) == 4'h0;
  endproperty
  property p_arrive;
    $rose(start_up_i) && !sens_i[0] && !mot_rev_o[0] |-> s_arrive;
  endproperty
  property p_startdn;
    $rose(sens_i[3]) && !acc_dn_i && !mot_rev_o[3] |-> ##[1:4] start_dn_o;
  endproperty
  property p_accstop;
    (acc_dn_i && sens_i[3])[*5] |-> !mot_fwd_o[3];
  endproperty
  // Zone one is never jogged, so reversal there is jam recovery
  property p_revcause;
    $rose(mot_rev_o[1]) |-> $past(sens_i[1], 2);
  endproperty
  property p_unjclr;
    (!sens_i[1])[*5] |-> !mot_rev_o[1];
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power lamp does not follow supply");
  a_ack: assert property (p_ack)
    else $error("bus answer not exactly one cycle");
  a_excl: assert property (p_excl)
    else $error("motor forward and reverse together");
  a_arrive: assert property (p_arrive)
    else $error("zone0 did not start on upstream start");
  a_startdn: assert property (p_startdn)
    else $error("head zone gave no downstream start");
  a_accstop: assert property (p_accstop)
    else $error("head zone runs while held");
  a_revcause: assert property (p_revcause)
    else $error("zone1 reversed with clear sensor");
  a_unjclr: assert property (p_unjclr)
    else $error("zone1 still reversing after clear");
endmodule // cvzs_chk

bind cvzs_top cvzs_chk #(.TICK_CYC(TICK_CYC)) i_cvzs_chk (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .sens_i(sens_i), .start_up_i(start_up_i), .acc_dn_i(acc_dn_i),
  .mpwr_ok_i(mpwr_ok_i), .start_dn_o(start_dn_o), .acc_up_o(acc_up_o),
  .mot_fwd_o(mot_fwd_o), .mot_rev_o(mot_rev_o), .mpwr_led_o(mpwr_led_o)
);

//--- dv/cvzs_nbr.sv
// Downstream neighbour model: accumulate level and next-zone sensor
`timescale 1ns/1ns
module cvzs_nbr #(
  parameter DLY = 30,
  parameter LEN = 20
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire start_dn_i,
  input wire hold_i,
  output logic acc_dn_o,
  output logic blk_dn_o
);
  int cnt_r;
  // Accumulate follows the host's hold intent
  assign acc_dn_o = hold_i;
  // Tray reaches the next sensor a while after a start
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_r <= 0;
    else if (start_dn_i && cnt_r == 0) cnt_r <= 1;
    else if (cnt_r != 0 && cnt_r < DLY + LEN) cnt_r <= cnt_r + 1;
    else if (!start_dn_i) cnt_r <= 0;
  end
  assign blk_dn_o = cnt_r > DLY && cnt_r < DLY + LEN;
endmodule // cvzs_nbr

//--- dv/cvzs_top_test.sv
// Self-checking bench for the conveyor zone sequencer
`timescale 1ns/1ns
`include "cvzs_map.vh"
module cvzs_top_test;
  localparam logic [31:0] FF = 32'hffffffff;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, start_up = 0;
  logic mpwr_ok = 0, hold = 0, aux = 0;
  logic [3:0] qual = 4'hf;
  logic [2:0] addr = 0;
  logic [3:0] sens = 0;
  logic [31:0] wdata = 0, rdata, e, m;
  wire wait_o, start_dn, acc_dn, blk_dn, flt;
  logic [31:0] exp_q[$], msk_q[$];
  logic [31:0] tm[3] = '{32'h04080305, 32'h00080305, 32'h04000305};
  logic [31:0] e1[3] = '{32'ha800, 32'ha000, 32'h3000};
  logic [31:0] e2[3] = '{32'he000, 32'ha000, 32'h3000};
  logic [31:0] m2[3] = '{32'hf800, 32'hb800, 32'hb800};
  int err_count = 0, cmp_count = 0, seed = 73, i, v;

  cvzs_top #(.TICK_CYC(20)) i_cvzs_top (
    .ref_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .sens_i(sens), .qual_i(qual),
    .aux_i(aux), .start_up_i(start_up), .acc_dn_i(acc_dn),
    .blk_dn_i(blk_dn), .mpwr_ok_i(mpwr_ok), .start_dn_o(start_dn),
    .acc_up_o(), .mot_fwd_o(), .mot_rev_o(), .mpwr_led_o(),
    .fault_led_o(flt));
  cvzs_nbr i_cvzs_nbr (.ref_clk_i(clk), .rst_b_i(rst_b),
    .start_dn_i(start_dn), .hold_i(hold), .acc_dn_o(acc_dn),
    .blk_dn_o(blk_dn));

  initial forever #25 clk = ~clk;

  // ==========
  // Bus tasks
  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input bit r, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= r;
    wr <= !r;
    addr <= a[4:2];
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 20);
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_o !== 1'b0) begin
      err_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, 1'b0, wait_o);
      finish_test();
    end
  endtask
  task automatic wrr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] x,
                       input logic [31:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    bus(1'b1, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========
  // Read result monitor
  always @(posedge clk) begin
    if (rd && wait_o === 1'b0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      cmp_count++;
      if ((rdata & m) !== (e & m)) begin
        err_count++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e & m, rdata & m);
      end
    end
  end

  // ==========
  // Scenarios
  initial begin
    cyc(20);
    rst_b <= 1'b1;
    mpwr_ok <= 1'b1;
    rdchk(`CVZS_OFF_CTRL, `CVZS_CTRL_RST, FF);
    rdchk(`CVZS_OFF_TIMER, `CVZS_TMR_RST, FF);
    rdchk(`CVZS_OFF_JOG, 32'h0, FF);
    rdchk(`CVZS_OFF_STAT, 32'h1000, 32'h100f);
    wrr(5'h1c, 32'h5a5a5a5a);
    rdchk(5'h1c, 32'h0, FF);
    wrr(`CVZS_OFF_NADDR, 32'h5);
    rdchk(`CVZS_OFF_NADDR, {24'h0, `CVZS_NADDR_MIN}, 32'hff);
    v = 16 + {$random(seed)} % 240;
    wrr(`CVZS_OFF_NADDR, v);
    rdchk(`CVZS_OFF_NADDR, v, 32'hff);
    mpwr_ok <= 1'b0;
    rdchk(`CVZS_OFF_STAT, 32'h0, 32'h1000);
    wrr(`CVZS_OFF_TIMER, tm[0]);
    for (i = 0; i < 2; i++) begin
      wrr(`CVZS_OFF_JOG, i ? 32'h44 : 32'h04);
      rdchk(`CVZS_OFF_IMAGE, i ? 32'h90000 : 32'h110000, 32'h190000);
    end
    wrr(`CVZS_OFF_JOG, 32'h0);
    // Tray lost before arrival, then a normal pass
    start_up <= 1'b1;
    cyc(10);
    start_up <= 1'b0;
    cyc(30);
    rdchk(`CVZS_OFF_IMAGE, 32'h14, 32'h16);
    cyc(120);
    rdchk(`CVZS_OFF_STAT, 32'h0, 32'h0f00);
    start_up <= 1'b1;
    cyc(10);
    start_up <= 1'b0;
    cyc(20);
    sens <= 4'h1;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h32, 32'h36);
    sens <= 4'h0;
    cyc(30);
    rdchk(`CVZS_OFF_IMAGE, 32'h10, 32'h10);
    cyc(80);
    rdchk(`CVZS_OFF_IMAGE, 32'h0, 32'h10);
    cyc(150);
    // Jam handling on zone one for several timer setups
    for (i = 0; i < 3; i++) begin
      wrr(`CVZS_OFF_TIMER, tm[i]);
      sens <= 4'h2;
      cyc(200);
      rdchk(`CVZS_OFF_IMAGE, e1[i], 32'hb800);
      cyc(120);
      rdchk(`CVZS_OFF_IMAGE, e2[i], m2[i]);
      // Fault lamp flashes only after a failed unjam
      v = 0;
      repeat (40) begin
        @(posedge clk);
        if (flt === 1'b1) v = 1;
      end
      cmp_count++;
      if (v != (i == 0)) begin
        err_count++;
        $display("ERROR t=%0t exp=%h got=%h", $time, i == 0, v);
      end
      sens <= 4'h0;
      cyc(10);
      rdchk(`CVZS_OFF_IMAGE, 32'h0, 32'h8800);
      cyc(100);
    end
    // Head zone held, then released
    sens <= 4'h8;
    cyc(10);
    sens <= 4'h0;
    cyc(100);
    hold <= 1'b1;
    sens <= 4'h8;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h24000000, 32'h34000000);
    hold <= 1'b0;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h30000000, 32'h34000000);
    // Zero clear interval: motor runs on until the next tray
    wrr(`CVZS_OFF_TIMER, 32'h04000005);
    cyc(40);
    sens <= 4'h0;
    cyc(100);
    rdchk(`CVZS_OFF_IMAGE, 32'h10000000, 32'h30000000);
    sens <= 4'h8;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h30000000, 32'h30000000);
    sens <= 4'h0;
    cyc(10);
    // Head release by aux pulse, one tray per pulse
    aux <= 1'b1;
    wrr(`CVZS_OFF_CTRL, 32'h0003000f);
    sens <= 4'h8;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h24000000, 32'h34000000);
    aux <= 1'b0;
    cyc(3);
    aux <= 1'b1;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h30000000, 32'h34000000);
    sens <= 4'h0;
    cyc(10);
    sens <= 4'h8;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h24000000, 32'h34000000);
    // Untrusted sensor reading is held
    wrr(`CVZS_OFF_CTRL, 32'h0000001f);
    qual <= 4'he;
    sens <= 4'h9;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h0, 32'h20);
    qual <= 4'hf;
    cyc(10);
    rdchk(`CVZS_OFF_IMAGE, 32'h20, 32'h20);
    sens <= 4'h0;
    cyc(20);
    finish_test();
  end
endmodule // cvzs_top_test
